/* File: verilog/diag_mux_pkg.sv */
/*
  Constants for the diagnostic output multiplexer control block: register
  indices, field positions, reset values and mode encodings.
  Assumes the serial-port decoder outside delivers register indices.
*/
package diag_mux_pkg;

  // ****************************************
  // register indices
  // ****************************************
  localparam logic [0:0] ADDR_DIAG_CONTROL = 1'h0;
  localparam logic [0:0] ADDR_CHANNEL_SELECT = 1'h1;

  // ****************************************
  // field positions of diagnostic_control
  // ****************************************
  localparam int OUT_ENABLE_BIT = 7;
  localparam int OVERRIDE_LEVEL_BIT = 6;
  localparam int MANUAL_LEVEL_BIT = 5;
  localparam int PROBE_SEL_HI = 4;
  localparam int PROBE_SEL_LO = 2;
  localparam int PATH_CFG_HI = 1;
  localparam int PATH_CFG_LO = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] DIAG_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CHANNEL_SELECT_RESET = 8'h00;

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {
    PATH_MANUAL = 2'h0,
    PATH_DIGITAL = 2'h1,
    PATH_ANALOG = 2'h2,
    PATH_INTERCONNECT = 2'h3
  } path_cfg_t;

  typedef enum logic [2:0] {
    PROBE_NONE = 3'h0,
    PROBE_ERROR_IN = 3'h1,
    PROBE_SELECT = 3'h2,
    PROBE_DATA_IN = 3'h3,
    PROBE_CLOCK = 3'h4,
    PROBE_UNUSED5 = 3'h5,
    PROBE_UNUSED6 = 3'h6,
    PROBE_DATA_OUT = 3'h7
  } probe_sel_t;

endpackage

/* File: verilog/diag_output_select.sv */
/*
  Combinational selection of the diagnostic pin level.
  Assumes decoded control fields and synchronous pin samples as inputs.
*/
module diag_output_select
  import diag_mux_pkg::*;
(
  // control fields
  input wire diag_mux_pkg::path_cfg_t path_cfg,
  input wire diag_mux_pkg::probe_sel_t probe_sel,
  input wire logic manual_level,
  input wire logic override_level,
  // monitor channels
  input wire logic digital_monitor,
  input wire logic analog_compare,
  // probed pins
  input wire logic error_in,
  input wire logic serial_select_n,
  input wire logic serial_data_in,
  input wire logic serial_clock,
  // result
  output logic level
);
  always_comb
  begin
    level = 1'b0;
    unique case (path_cfg)
      PATH_MANUAL: level = manual_level;
      PATH_DIGITAL: level = digital_monitor;
      PATH_ANALOG: level = analog_compare;
      PATH_INTERCONNECT:
      begin
        unique case (probe_sel)
          PROBE_ERROR_IN: level = error_in;
          PROBE_SELECT: level = serial_select_n;
          PROBE_DATA_IN: level = serial_data_in;
          PROBE_CLOCK: level = serial_clock;
          PROBE_DATA_OUT: level = override_level;
          default: level = 1'b0;
        endcase
      end
    endcase
  end
endmodule // diag_output_select

/* File: verilog/diag_output_mux_control.sv */
/*
  Diagnostic output multiplexer control: the two control registers, the
  diagnostic pin driver and the data-out override.
  Assumes a serial-port decoder supplies one-cycle write strobes with a
  register index, and that monitor channels arrive synchronous to clk.
*/

// Contract
// - enable bit tristates or drives diagnostic pin
// - override sets data-out level in loopback
// - path 00 drives manual level bit
// - probe select routes chosen input pin
// - path config picks multiplexer mode
// - channel select applies only when probe zero
// - channel select readable, writable, reset zero
// - control writes only while lock clear
// - control register reset to zero
module diag_output_mux_control
  import diag_mux_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic device_reset_state,
  // register access
  input wire logic reg_write,
  input wire logic [0:0] reg_index,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic control_write_lock,
  // serial pins
  input wire logic serial_select_n,
  input wire logic serial_data_in,
  input wire logic serial_clock,
  input wire logic serial_response_data,
  output logic serial_data_out,
  // monitor sources
  input wire logic error_in,
  input wire logic [255:0] digital_channels,
  input wire logic [255:0] analog_compare_channels,
  // analog multiplexer steering
  output logic [7:0] analog_channel_select,
  // diagnostic pin
  output logic diagnostic_output_pin_o,
  output logic diagnostic_output_pin_oe_n
);

  logic [7:0] diagnostic_control_reg;
  logic [7:0] diagnostic_control_next;
  logic [7:0] diagnostic_channel_select_reg;
  logic [7:0] diagnostic_channel_select_next;
  logic [7:0] applied_select_reg;
  logic [7:0] applied_select_next;
  logic pin_level_reg;
  logic pin_level_next;
  logic pin_oe_n_reg;
  logic pin_oe_n_next;
  logic data_out_reg;
  logic data_out_next;
  logic [7:0] read_data_reg;
  logic [7:0] read_data_next;
  logic mux_level;
  path_cfg_t path_cfg;
  probe_sel_t probe_sel;
  logic out_enable;
  logic sdo_override;

  // ****************************************
  // field decode
  // ****************************************
  assign out_enable = diagnostic_control_reg[OUT_ENABLE_BIT];
  assign path_cfg = path_cfg_t'(diagnostic_control_reg[PATH_CFG_HI:PATH_CFG_LO]);
  assign probe_sel = probe_sel_t'(diagnostic_control_reg[PROBE_SEL_HI:PROBE_SEL_LO]);

  // ****************************************
  // register file
  // ****************************************
  // control register: the reset state wins over a write in the same cycle
  always_comb
  begin
    diagnostic_control_next = diagnostic_control_reg;
    if (device_reset_state)
      diagnostic_control_next = DIAG_CONTROL_RESET;
    else if (reg_write && reg_index == ADDR_DIAG_CONTROL && !control_write_lock)
      diagnostic_control_next = reg_wdata;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      diagnostic_control_reg <= DIAG_CONTROL_RESET;
    else
      diagnostic_control_reg <= diagnostic_control_next;
  end

  // channel select register: the control lock does not cover it
  always_comb
  begin
    diagnostic_channel_select_next = diagnostic_channel_select_reg;
    if (device_reset_state)
      diagnostic_channel_select_next = CHANNEL_SELECT_RESET;
    else if (reg_write && reg_index == ADDR_CHANNEL_SELECT)
      diagnostic_channel_select_next = reg_wdata;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      diagnostic_channel_select_reg <= CHANNEL_SELECT_RESET;
    else
      diagnostic_channel_select_reg <= diagnostic_channel_select_next;
  end

  // ****************************************
  // read back
  // ****************************************
  // registered so the serial decoder sees a settled word one clock on
  always_comb
  begin
    read_data_next = diagnostic_control_reg;
    if (reg_index == ADDR_CHANNEL_SELECT)
      read_data_next = diagnostic_channel_select_reg;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      read_data_reg <= 8'h00;
    else
      read_data_reg <= read_data_next;
  end

  assign reg_rdata = read_data_reg;

  // ****************************************
  // multiplexer and pin drivers
  // ****************************************
  diag_output_select u_select (
    .path_cfg(path_cfg),
    .probe_sel(probe_sel),
    .manual_level(diagnostic_control_reg[MANUAL_LEVEL_BIT]),
    .override_level(diagnostic_control_reg[OVERRIDE_LEVEL_BIT]),
    .digital_monitor(digital_channels[applied_select_reg]),
    .analog_compare(analog_compare_channels[applied_select_reg]),
    .error_in(error_in),
    .serial_select_n(serial_select_n),
    .serial_data_in(serial_data_in),
    .serial_clock(serial_clock),
    .level(mux_level)
  );

  // ****************************************
  // channel steering
  // ****************************************
  // the applied channel is registered, so a channel change reaches the pin one clock after a mode change
  always_comb
  begin
    // channel applies only with no probe
    applied_select_next = 8'h00;
    if (probe_sel == PROBE_NONE)
      applied_select_next = diagnostic_channel_select_reg;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      applied_select_reg <= 8'h00;
    else
      applied_select_reg <= applied_select_next;
  end

  // ****************************************
  // diagnostic pin driver
  // ****************************************
  always_comb
  begin
    pin_oe_n_next = !out_enable;
    pin_level_next = 1'b0;
    if (out_enable)
      pin_level_next = mux_level;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_level_reg <= 1'b0;
      pin_oe_n_reg <= 1'b1;
    end
    else
    begin
      pin_level_reg <= pin_level_next;
      pin_oe_n_reg <= pin_oe_n_next;
    end
  end

  // ****************************************
  // data-out override
  // ****************************************
  // all three conditions of the override live in the control register
  assign sdo_override = out_enable && path_cfg == PATH_INTERCONNECT && probe_sel == PROBE_DATA_OUT;

  always_comb
  begin
    data_out_next = serial_response_data;
    if (serial_select_n && sdo_override)
      data_out_next = diagnostic_control_reg[OVERRIDE_LEVEL_BIT];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      data_out_reg <= 1'b0;
    else
      data_out_reg <= data_out_next;
  end

  assign analog_channel_select = applied_select_reg;
  assign diagnostic_output_pin_o = pin_level_reg;
  assign diagnostic_output_pin_oe_n = pin_oe_n_reg;
  assign serial_data_out = data_out_reg;

endmodule // diag_output_mux_control

/* File: test/diag_output_mux_control_checker.sv */
/* checker for the diag mux control block;
   mirrors both registers from the write port */
module diag_output_mux_control_checker(
  // clock, reset and register port
  input wire logic clk,
  input wire logic rst,
  input wire logic device_reset_state,
  input wire logic reg_write,
  input wire logic control_write_lock,
  input wire logic [0:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] analog_channel_select,
  // pins and monitors
  input wire logic serial_select_n,
  input wire logic serial_data_in,
  input wire logic serial_clock,
  input wire logic serial_response_data,
  input wire logic serial_data_out,
  input wire logic error_in,
  input wire logic diagnostic_output_pin_o,
  input wire logic diagnostic_output_pin_oe_n,
  input wire logic [255:0] digital_channels,
  input wire logic [255:0] analog_compare_channels
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // register mirror
  // ********
  logic [7:0] c_reg, c_next, s_reg, s_next, ch_reg, ch_next;
  always_comb
  begin
    c_next = c_reg;
    s_next = s_reg;
    // applied channel, one clock behind the registers
    ch_next = c_reg[4:2] == 3'h0 ? s_reg : 8'h00;
    if (device_reset_state)
      {c_next, s_next} = 16'h0000;
    else if (reg_write && reg_index)
      s_next = reg_wdata;
    else if (reg_write && !control_write_lock)
      c_next = reg_wdata;
  end
  always_ff @(posedge clk or posedge rst)
    if (rst)
      {c_reg, s_reg, ch_reg} <= 24'h000000;
    else
      {c_reg, s_reg, ch_reg} <= {c_next, s_next, ch_next};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_oe; diagnostic_output_pin_oe_n == !$past(c_reg[7]); endproperty
  a_oe: assert property (p_oe) else $error("enable wrong");
  property p_man; $past(c_reg[7] && c_reg[1:0] == 2'h0) |-> diagnostic_output_pin_o == $past(c_reg[5]);
  endproperty
  a_man: assert property (p_man) else $error("manual level wrong");
  property p_ovr; $past(serial_select_n && c_reg[7] && c_reg[4:0] == 5'h1F) |-> serial_data_out == $past(c_reg[6]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override wrong");
  property p_norm; $past(!serial_select_n) |-> serial_data_out == $past(serial_response_data); endproperty
  a_norm: assert property (p_norm) else $error("response wrong");
  property p_err; $past(c_reg[7] && c_reg[4:0] == 5'h07) |-> diagnostic_output_pin_o == $past(error_in); endproperty
  a_err: assert property (p_err) else $error("error probe wrong");
  property p_sck; $past(c_reg[7] && c_reg[4:0] == 5'h13) |-> diagnostic_output_pin_o == $past(serial_clock);
  endproperty
  a_sck: assert property (p_sck) else $error("clock probe wrong");
  property p_dig; $past(c_reg[7] && c_reg[4:0] == 5'h01) |->
    diagnostic_output_pin_o == $past(digital_channels[ch_reg]);
  endproperty
  a_dig: assert property (p_dig) else $error("digital wrong");
  property p_acs; analog_channel_select == $past(c_reg[4:2] == 3'h0 ? s_reg : 8'h00); endproperty
  a_acs: assert property (p_acs) else $error("channel wrong");
  property p_rd; $past(!reg_write && !device_reset_state) |-> reg_rdata == $past(reg_index ? s_reg : c_reg);
  endproperty
  a_rd: assert property (p_rd) else $error("read wrong");
endmodule // diag_output_mux_control_checker
bind diag_output_mux_control diag_output_mux_control_checker u_chk(
  .clk(clk),
  .rst(rst),
  .device_reset_state(device_reset_state),
  .reg_write(reg_write),
  .control_write_lock(control_write_lock),
  .reg_index(reg_index),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .analog_channel_select(analog_channel_select),
  .serial_select_n(serial_select_n),
  .serial_data_in(serial_data_in),
  .serial_clock(serial_clock),
  .serial_response_data(serial_response_data),
  .serial_data_out(serial_data_out),
  .error_in(error_in),
  .diagnostic_output_pin_o(diagnostic_output_pin_o),
  .diagnostic_output_pin_oe_n(diagnostic_output_pin_oe_n),
  .digital_channels(digital_channels),
  .analog_compare_channels(analog_compare_channels)
);

/* File: test/diag_host_model.sv */
/* host side of the register port;
   assumes the caller sits just after a rising edge */
module diag_host_model(
  // register port
  input wire logic clk,
  output logic reg_write,
  output logic [0:0] reg_index,
  output logic [7:0] reg_wdata,
  output logic control_write_lock
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_write, reg_index, reg_wdata, control_write_lock} = 11'h000;
  // lock held low unless a refusal is wanted
  task automatic wr(input logic [0:0] i, input logic [7:0] d, input logic l);
    {reg_write, reg_index, reg_wdata, control_write_lock} = {1'h1, i, d, l};
    @(posedge clk) #1;
    reg_write = 1'h0;
    // released data shows the complement of the last word, not the word itself
    reg_wdata = ~d;
  endtask
endmodule // diag_host_model

/* File: test/tb_diag_output_mux_control.sv */
/* self-checking bench for the diag mux control block;
   assumes the host model and the bound checker */
module tb_diag_output_mux_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, dev = 0, ssn = 1, sdi = 0, sck = 0, resp = 0, err = 0, e, l;
  logic wr, lk, sdo, po, oen;
  logic [0:0] idx;
  logic [7:0] wd, rd, acs, d, ch = 0, p = 0, c = 0, s = 0;
  logic [255:0] dig = 0, ana = 0;
  wire logic [4:0] pins = {sck, sdi, ssn, err, 1'h0};
  integer seed = 32'h1fde7047, n_errors = 0, n_compared = 0, cyc = 0;
  diag_host_model u_host(.clk(clk), .reg_write(wr), .reg_index(idx), .reg_wdata(wd), .control_write_lock(lk));
  diag_output_mux_control u_dut(.clk(clk), .rst(rst), .device_reset_state(dev), .reg_write(wr),
    .reg_index(idx), .reg_wdata(wd), .reg_rdata(rd), .control_write_lock(lk), .serial_select_n(ssn),
    .serial_data_in(sdi), .serial_clock(sck), .serial_response_data(resp), .serial_data_out(sdo),
    .error_in(err), .digital_channels(dig), .analog_compare_channels(ana), .analog_channel_select(acs),
    .diagnostic_output_pin_o(po), .diagnostic_output_pin_oe_n(oen));
  initial forever #10 clk = ~clk;
  task print_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [7:0] g, x);
    n_compared++;
    if (g !== x)
    begin
      n_errors++;
      $display("Error at %0t got %h exp %h", $time, g, x);
    end
  endtask
  // hang guard: run needs about 2100 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  // ********
  // main sequence
  // ********
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst = 0;
    @(posedge clk) #1;
    chk(8'(oen), 8'h01);
    chk(rd, 8'h00);
    for (int k = 0; k < 1024; k++)
    begin
      {ssn, sdi, sck, resp, err} = 5'($random(seed));
      dig = {8{$random(seed)}};
      ana = {8{$random(seed)}};
      dev = ($random(seed) & 15) == 0;
      d = k < 512 ? 8'(k >> 1) : 8'($random(seed));
      l = k >= 512 && ($random(seed) & 3) == 0;
      u_host.wr(1'(k), d, l);
      if (dev)
        {c, s} = 16'h0000;
      else if (k[0])
        s = d;
      else if (!l)
        c = d;
      dev = 0;
      @(posedge clk) #1;
      // the monitor index on the pin trails the registers by one more clock
      p = ch;
      ch = c[4:2] == 3'h0 ? s : 8'h00;
      case (c[1:0])
        2'h0: e = c[5];
        2'h1: e = dig[p];
        2'h2: e = ana[p];
        default: e = c[4:2] == 3'h7 ? c[6] : c[4:2] inside {[3'h1:3'h4]} ? pins[c[4:2]] : 1'h0;
      endcase
      chk(8'(oen), 8'(!c[7]));
      chk(8'(po), 8'(c[7] && e));
      chk(8'(sdo), 8'(ssn && c[7] && c[4:0] == 5'h1F ? c[6] : resp));
      chk(acs, ch);
      chk(rd, k[0] ? s : c);
    end
    print_verdict();
  end
endmodule // tb_diag_output_mux_control
